/* File: tte_pkg.sv */
`default_nettype none
package tte_pkg;
  localparam int          TRIP_COUNT     = 6;
  localparam int          ADDR_WIDTH     = 16;
  // trip index inside the comparator vector
  localparam int          TRIP_AUX0      = 0;
  localparam int          TRIP_AUX1      = 1;
  localparam int          TRIP_AUX2      = 2;
  localparam int          TRIP_AUX3      = 3;
  localparam int          TRIP_HOT       = 4;
  localparam int          TRIP_CAT       = 5;
  // flag field positions
  localparam int          RISE_LSB       = 0;
  localparam int          FALL_LSB       = 8;
  // byte addresses
  localparam logic [15:0] OFF_CTRL_LO    = 16'h1041;
  localparam logic [15:0] OFF_CTRL_HI    = 16'h1042;
  localparam logic [15:0] OFF_STAT_LO    = 16'h1044;
  localparam logic [15:0] OFF_STAT_HI    = 16'h1045;
  localparam logic [15:0] OFF_CALTEMP    = 16'h1046;
  localparam logic [15:0] OFF_THOFFSET   = 16'h1047;
  localparam logic [15:0] OFF_RELTEMP    = 16'h1048;
  localparam logic [15:0] OFF_FLAGS_LO   = 16'h105E;
  localparam logic [15:0] OFF_FLAGS_HI   = 16'h105F;
  // reset values
  localparam logic [15:0] RST_CTRL       = 16'h0000;
  localparam logic [15:0] RST_STAT       = 16'h0000;
  localparam logic [7:0]  RST_CALTEMP    = 8'hFF;
  localparam logic [7:0]  RST_THOFFSET   = 8'h00;
  localparam logic [7:0]  RST_RELTEMP    = 8'h00;
  localparam logic [15:0] RST_FLAGS      = 16'h0000;
  localparam logic [7:0]  RD_UNMAPPED    = 8'h00;
endpackage : tte_pkg
`default_nettype wire

/* File: tte_edge_detect.sv */
`timescale 1ns/1ps
`default_nettype none
module tte_edge_detect #(
  parameter int WIDTH = 6
) (
  input  wire logic             sysClk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] risePulse,
  output logic      [WIDTH-1:0] fallPulse
);
  logic [WIDTH-1:0] prev_q;

  // comparators assumed low at reset, so a high level after release reads as a rise
  always_ff @(posedge sysClk) begin
    if (!resetn) begin
      prev_q <= '0;
    end else begin
      prev_q <= level;
    end
  end

  assign risePulse = level & ~prev_q;
  assign fallPulse = ~level & prev_q;

  rise_fall_excl_a : assert property (@(posedge sysClk) disable iff (!resetn)
    (risePulse & fallPulse) == '0)
    else $error("rise and fall at once");
endmodule : tte_edge_detect
`default_nettype wire

/* File: tte_w1c_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module tte_w1c_flags #(
  parameter int WIDTH = 16
) (
  input  wire logic             sysClk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] setMask,
  input  wire logic [WIDTH-1:0] clrMask,
  output logic      [WIDTH-1:0] flags_q
);
  logic [WIDTH-1:0] flags_d;

  // set wins over a clear in the same cycle, so no event is lost
  assign flags_d = (flags_q & ~clrMask) | setMask;

  always_ff @(posedge sysClk) begin
    if (!resetn) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  flag_sticky_a : assert property (
    @(posedge sysClk) disable iff (!resetn)
    $past(resetn) |-> ((flags_q & ~$past(flags_q)) == ($past(setMask) & ~$past(flags_q))))
    else $error("flag rose without set");

  flag_clear_only_a : assert property (
    @(posedge sysClk) disable iff (!resetn)
    $past(resetn) |-> (($past(flags_q) & ~flags_q) ==
                       ($past(flags_q) & $past(clrMask) & ~$past(setMask))))
    else $error("flag fell without a write of one");
endmodule : tte_w1c_flags
`default_nettype wire

/* File: tte_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tte_top (
  input  wire logic                           sysClk,
  input  wire logic                           resetn,
  // trip comparator levels, one per trip point
  input  wire logic [tte_pkg::TRIP_COUNT-1:0] tripLevel,
  input  wire logic [15:0]                    sensorStatusIn,
  input  wire logic [7:0]                     calTempIn,
  input  wire logic [7:0]                     relTempIn,
  input  wire logic                           thermometerEnable,
  // byte-wide register port
  input  wire logic [tte_pkg::ADDR_WIDTH-1:0] regAddr,
  input  wire logic                           regWrite,
  input  wire logic                           regRead,
  input  wire logic [7:0]                     regWdata,
  output logic      [7:0]                     regRdata_q,
  output logic                                regRvalid_q,
  output logic                                hostIntMsg_q,
  output logic      [15:0]                    sensorControl_q,
  output logic      [7:0]                     thermometerOffset_q
);
  import tte_pkg::*;

  logic [TRIP_COUNT-1:0] risePulse;
  logic [TRIP_COUNT-1:0] fallPulse;
  logic [15:0]           flagSet;
  logic [15:0]           flagClr;
  logic [15:0]           flags_q;
  logic [15:0]           sensorStatus_q;
  logic [7:0]            calTemp_q;
  logic [7:0]            relTemp_q;
  logic [7:0]            rdMux;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    hit = (a == off);
  endfunction : hit

  // checks rest during reset; the reset checks opt back in on their own
  default clocking cb @(posedge sysClk); endclocking
  default disable iff (!resetn);

  sequence riseOf(int i);
    !tripLevel[i] ##1 tripLevel[i];
  endsequence

  sequence fallOf(int i);
    tripLevel[i] ##1 !tripLevel[i];
  endsequence

  sequence readAt(logic [15:0] off);
    regRead && hit(regAddr, off);
  endsequence

  sequence writeAt(logic [15:0] off);
    regWrite && hit(regAddr, off);
  endsequence

  //////////////////////////////////////////////////////////////////////////////
  // trip events

  tte_edge_detect #(
    .WIDTH (TRIP_COUNT)
  ) uEdge (
    .sysClk    (sysClk),
    .resetn    (resetn),
    .level     (tripLevel),
    .risePulse (risePulse),
    .fallPulse (fallPulse)
  );

  always_comb begin
    flagSet = '0;
    flagSet[RISE_LSB +: TRIP_COUNT] = risePulse;
    flagSet[FALL_LSB +: TRIP_COUNT] = fallPulse;
  end

  aux0_fall_flag_a : assert property (
    fallOf(TRIP_AUX0) |=> flags_q[8])
    else $error("aux0 fall did not set bit 8");

  aux0_fall_only_a : assert property (
    (!fallPulse[0] && !flags_q[8]) |=> !flags_q[8])
    else $error("bit 8 set without aux0 fall");

  other_fall_flags_a : assert property (
    |fallPulse[5:1] |=> ((flags_q[13:9] & $past(fallPulse[5:1])) == $past(fallPulse[5:1])))
    else $error("falling flag not set");

  hot_fall_flag_a : assert property (
    fallOf(TRIP_HOT) |=> flags_q[12])
    else $error("hot fall did not set bit 12");

  cat_fall_flag_a : assert property (
    fallOf(TRIP_CAT) |=> flags_q[13])
    else $error("cat fall did not set bit 13");

  cat_rise_flag_a : assert property (
    riseOf(TRIP_CAT) |=> flags_q[5])
    else $error("cat rise did not set bit 5");

  hot_rise_flag_a : assert property (
    riseOf(TRIP_HOT) |=> flags_q[4])
    else $error("hot rise did not set bit 4");

  aux32_rise_flag_a : assert property (
    |risePulse[3:2] |=> ((flags_q[3:2] & $past(risePulse[3:2])) == $past(risePulse[3:2])))
    else $error("aux3 or aux2 flag not set");

  aux3_rise_flag_a : assert property (
    riseOf(TRIP_AUX3) |=> flags_q[3])
    else $error("aux3 rise did not set bit 3");

  aux1_rise_flag_a : assert property (
    riseOf(TRIP_AUX1) |=> flags_q[1])
    else $error("aux1 rise did not set bit 1");

  aux0_rise_flag_a : assert property (
    riseOf(TRIP_AUX0) |=> flags_q[0])
    else $error("aux0 rise did not set bit 0");

  rise_flags_kept_a : assert property (
    (flags_q[5:0] != 6'h00 && !regWrite) |=> ((flags_q[5:0] & $past(flags_q[5:0])) == $past(flags_q[5:0])))
    else $error("rising flag dropped without a write");

  reserved_zero_a : assert property (
    (flags_q[7:6] == 2'b00) && (flags_q[15:14] == 2'b00))
    else $error("reserved flag bit set");

  // write one to clear, per byte lane; reserved bits never set so they read zero
  always_comb begin
    flagClr = '0;
    if (regWrite && hit(regAddr, OFF_FLAGS_LO)) begin
      flagClr[7:0] = regWdata;
    end
    if (regWrite && hit(regAddr, OFF_FLAGS_HI)) begin
      flagClr[15:8] = regWdata;
    end
  end

  w1c_clear_a : assert property (
    (regWrite && hit(regAddr, OFF_FLAGS_LO) && regWdata[0] && !risePulse[0]) |=> !flags_q[0])
    else $error("write one did not clear bit 0");

  w1c_clear_lo_a : assert property (
    writeAt(OFF_FLAGS_LO) |=> ((flags_q[7:0] & $past(regWdata) & ~$past(flagSet[7:0])) == 8'h00))
    else $error("low flag byte not cleared");

  w1c_clear_hi_a : assert property (
    writeAt(OFF_FLAGS_HI) |=> ((flags_q[15:8] & $past(regWdata) & ~$past(flagSet[15:8])) == 8'h00))
    else $error("high flag byte not cleared");

  flag_hold_a : assert property (
    (flags_q[4] && !(regWrite && hit(regAddr, OFF_FLAGS_LO))) |=> flags_q[4])
    else $error("hot flag dropped without clear");

  tte_w1c_flags #(
    .WIDTH (16)
  ) uFlags (
    .sysClk  (sysClk),
    .resetn  (resetn),
    .setMask (flagSet),
    .clrMask (flagClr),
    .flags_q (flags_q)
  );

  // one message per cycle with a new rising trip; cause is left in the flags
  always_ff @(posedge sysClk) begin
    if (!resetn) begin
      hostIntMsg_q <= 1'b0;
    end else begin
      hostIntMsg_q <= |risePulse;
    end
  end

  int_message_a : assert property (
    |risePulse |=> hostIntMsg_q ##1 (hostIntMsg_q == $past(|risePulse)))
    else $error("no interrupt message on rising trip");

  int_quiet_a : assert property (
    !(|risePulse) |=> !hostIntMsg_q)
    else $error("interrupt message without rising trip");

  //////////////////////////////////////////////////////////////////////////////
  // mirrored sensor registers

  always_ff @(posedge sysClk) begin
    if (!resetn) begin
      sensorStatus_q <= RST_STAT;
      relTemp_q      <= RST_RELTEMP;
    end else begin
      sensorStatus_q <= sensorStatusIn;
      relTemp_q      <= relTempIn;
    end
  end

  status_track_a : assert property (
    1'b1 |=> sensorStatus_q == $past(sensorStatusIn))
    else $error("status register did not follow sensor");

  reltemp_track_a : assert property (
    1'b1 |=> relTemp_q == $past(relTempIn))
    else $error("relative temperature did not follow sensor");

  rst_status_a : assert property (
    disable iff (1'b0) !resetn |=> sensorStatus_q == RST_STAT)
    else $error("status register reset value wrong");

  rst_reltemp_a : assert property (
    disable iff (1'b0) !resetn |=> relTemp_q == RST_RELTEMP)
    else $error("relative temperature reset value wrong");

  // holds the last reading while the thermometer is off, rather than garbage
  always_ff @(posedge sysClk) begin
    if (!resetn) begin
      calTemp_q <= RST_CALTEMP;
    end else if (thermometerEnable) begin
      calTemp_q <= calTempIn;
    end
  end

  caltemp_hold_a : assert property (
    !thermometerEnable |=> $stable(calTemp_q))
    else $error("calibrated temperature moved while disabled");

  caltemp_track_a : assert property (
    thermometerEnable |=> calTemp_q == $past(calTempIn))
    else $error("calibrated temperature not taken while enabled");

  rst_caltemp_a : assert property (
    disable iff (1'b0) !resetn |=> calTemp_q == RST_CALTEMP)
    else $error("calibrated temperature reset value wrong");

  always_ff @(posedge sysClk) begin
    if (!resetn) begin
      thermometerOffset_q <= RST_THOFFSET;
    end else if (regWrite && hit(regAddr, OFF_THOFFSET)) begin
      thermometerOffset_q <= regWdata;
    end
  end

  offset_write_a : assert property (
    writeAt(OFF_THOFFSET) |=> thermometerOffset_q == $past(regWdata))
    else $error("offset write lost");

  offset_hold_a : assert property (
    !(regWrite && hit(regAddr, OFF_THOFFSET)) |=> $stable(thermometerOffset_q))
    else $error("offset changed without a write");

  rst_offset_a : assert property (
    disable iff (1'b0) !resetn |=> thermometerOffset_q == RST_THOFFSET)
    else $error("offset reset value wrong");

  // field layout unknown here, so every bit is plain read-write
  always_ff @(posedge sysClk) begin
    if (!resetn) begin
      sensorControl_q <= RST_CTRL;
    end else begin
      if (regWrite && hit(regAddr, OFF_CTRL_LO)) begin
        sensorControl_q[7:0] <= regWdata;
      end
      if (regWrite && hit(regAddr, OFF_CTRL_HI)) begin
        sensorControl_q[15:8] <= regWdata;
      end
    end
  end

  ctrl_lo_write_a : assert property (
    writeAt(OFF_CTRL_LO) |=> sensorControl_q[7:0] == $past(regWdata))
    else $error("control low byte write lost");

  ctrl_hi_write_a : assert property (
    writeAt(OFF_CTRL_HI) |=> sensorControl_q[15:8] == $past(regWdata))
    else $error("control high byte write lost");

  rst_control_a : assert property (
    disable iff (1'b0) !resetn |=> sensorControl_q == RST_CTRL)
    else $error("control reset value wrong");

  //////////////////////////////////////////////////////////////////////////////
  // read path

  always_comb begin
    case (regAddr)
      OFF_CTRL_LO:  rdMux = sensorControl_q[7:0];
      OFF_CTRL_HI:  rdMux = sensorControl_q[15:8];
      OFF_STAT_LO:  rdMux = sensorStatus_q[7:0];
      OFF_STAT_HI:  rdMux = sensorStatus_q[15:8];
      OFF_CALTEMP:  rdMux = calTemp_q;
      OFF_THOFFSET: rdMux = thermometerOffset_q;
      OFF_RELTEMP:  rdMux = relTemp_q;
      OFF_FLAGS_LO: rdMux = flags_q[7:0];
      OFF_FLAGS_HI: rdMux = flags_q[15:8];
      default:      rdMux = RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge sysClk) begin
    if (!resetn) begin
      regRdata_q  <= RD_UNMAPPED;
      regRvalid_q <= 1'b0;
    end else begin
      regRvalid_q <= regRead;
      if (regRead) begin
        regRdata_q <= rdMux;
      end
    end
  end

  status_read_a : assert property (
    readAt(OFF_STAT_LO) |=> regRvalid_q && regRdata_q == $past(sensorStatus_q[7:0]))
    else $error("status read mismatch");

  status_hi_read_a : assert property (
    readAt(OFF_STAT_HI) |=> regRdata_q == $past(sensorStatus_q[15:8]))
    else $error("status high byte read mismatch");

  flags_lo_read_a : assert property (
    readAt(OFF_FLAGS_LO) |=> regRdata_q == $past(flags_q[7:0]))
    else $error("low flag byte read mismatch");

  flags_hi_read_a : assert property (
    readAt(OFF_FLAGS_HI) |=> regRdata_q == $past(flags_q[15:8]))
    else $error("high flag byte read mismatch");

  caltemp_read_a : assert property (
    readAt(OFF_CALTEMP) |=> regRdata_q == $past(calTemp_q))
    else $error("calibrated temperature read mismatch");

  reltemp_read_a : assert property (
    readAt(OFF_RELTEMP) |=> regRdata_q == $past(relTemp_q))
    else $error("relative temperature read mismatch");

  offset_read_a : assert property (
    readAt(OFF_THOFFSET) |=> regRdata_q == $past(thermometerOffset_q))
    else $error("offset read mismatch");

  ctrl_hi_read_a : assert property (
    readAt(OFF_CTRL_HI) |=> regRdata_q == $past(sensorControl_q[15:8]))
    else $error("control high byte read mismatch");

  read_valid_a : assert property (
    regRead |=> regRvalid_q)
    else $error("read answer missing");

  read_idle_a : assert property (
    !regRead |=> !regRvalid_q && $stable(regRdata_q))
    else $error("read answer without read");

  rst_outputs_a : assert property (
    disable iff (1'b0) !resetn |=> !regRvalid_q && !hostIntMsg_q && regRdata_q == RD_UNMAPPED)
    else $error("port reset values wrong");
endmodule : tte_top
`default_nettype wire

/* File: tte_sensor_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tte_sensor_model #(
  parameter logic [47:0] THRESH = 48'hC0A0_8060_4020
) (
  input  wire logic [7:0]  temp,
  output logic      [5:0]  tripLevel,
  output logic      [15:0] statusOut,
  output logic      [7:0]  relTemp,
  output logic      [7:0]  calTemp
);
  // comparator high at or above its trip point, one step crosses many
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      tripLevel[i] = temp >= THRESH[8*i +: 8];
    end
  end
  assign statusOut = {10'h000, tripLevel};
  assign relTemp   = temp;
  // xor keeps it apart from the 0xff reset value at temp 0
  assign calTemp   = temp ^ 8'h3C;
endmodule : tte_sensor_model
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tte_pkg::*;
  localparam logic [47:0] THR = 48'hC0A0_8060_4020;
  localparam logic [31:0] CORNER = 32'h3F40_00FF;
  logic        sysClk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  temp = 8'h00;
  logic        thermometerEnable = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [7:0]  regWdata = 8'h00;
  logic [5:0]  tripLevel;
  logic [15:0] sensorStatus, sensorControl_q, acc;
  logic [7:0]  relTemp, calTemp, regRdata_q, thermometerOffset_q, oldT;
  logic        regRvalid_q, hostIntMsg_q;
  logic [31:0] seed = 32'hcc77_7dfd;
  int          errors = 0;
  int          samples_checked = 0;
  int          msgs;
  always #5 sysClk = ~sysClk;
  tte_sensor_model #(.THRESH(THR)) model (.temp(temp), .tripLevel(tripLevel),
    .statusOut(sensorStatus), .relTemp(relTemp), .calTemp(calTemp));
  tte_top dut (.sysClk(sysClk), .resetn(resetn), .tripLevel(tripLevel),
    .sensorStatusIn(sensorStatus), .calTempIn(calTemp), .relTempIn(relTemp),
    .thermometerEnable(thermometerEnable), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata_q(regRdata_q),
    .regRvalid_q(regRvalid_q), .hostIntMsg_q(hostIntMsg_q),
    .sensorControl_q(sensorControl_q), .thermometerOffset_q(thermometerOffset_q));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [5:0] trips(input logic [7:0] t);
    for (int i = 0; i < 6; i++) begin
      trips[i] = t >= THR[8*i +: 8];
    end
  endfunction : trips
  function automatic logic [15:0] evFlags(input logic [7:0] o, input logic [7:0] n);
    evFlags = {2'b00, trips(o) & ~trips(n), 2'b00, trips(n) & ~trips(o)};
  endfunction : evFlags
  task automatic results;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  task automatic compareByte(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t exp %h got %h", $time, e, g);
    end
  endtask : compareByte
  task automatic compareCount(input int e, input int g);
    samples_checked++;
    if (g != e) begin
      errors++;
      $display("unexpected at %0t exp %h got %h", $time, e, g);
    end
  endtask : compareCount
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sysClk);
    regAddr  = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge sysClk);
    regWrite = 1'b0;
  endtask : wr
  // bounded wait, a lost read answer ends the run
  task automatic rdChk(input logic [15:0] a, input logic [7:0] e);
    int n;
    @(negedge sysClk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge sysClk);
    regRead = 1'b0;
    n = 0;
    while (regRvalid_q !== 1'b1 && n < 4) begin
      @(negedge sysClk);
      n++;
    end
    if (n == 4) begin
      errors++;
      results;
    end else begin
      compareByte(e, regRdata_q);
    end
  endtask : rdChk
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge sysClk);
    resetn = 1'b1;
    rdChk(OFF_CTRL_LO, 8'h00);
    rdChk(OFF_CTRL_HI, 8'h00);
    rdChk(OFF_STAT_LO, 8'h00);
    rdChk(OFF_STAT_HI, 8'h00);
    rdChk(OFF_CALTEMP, 8'hFF);
    rdChk(OFF_THOFFSET, 8'h00);
    rdChk(OFF_RELTEMP, 8'h00);
    rdChk(OFF_FLAGS_LO, 8'h00);
    rdChk(16'h1043, 8'h00);
    seed = lfsr(seed);
    wr(OFF_THOFFSET, seed[7:0]);
    wr(OFF_CALTEMP, 8'h00);
    wr(OFF_CTRL_LO, seed[15:8]);
    wr(OFF_CTRL_HI, seed[23:16]);
    rdChk(OFF_THOFFSET, seed[7:0]);
    compareByte(seed[7:0], thermometerOffset_q);
    rdChk(OFF_CALTEMP, 8'hFF);
    rdChk(OFF_CTRL_HI, seed[23:16]);
    compareByte(seed[15:8], sensorControl_q[7:0]);
    compareByte(seed[23:16], sensorControl_q[15:8]);
    thermometerEnable = 1'b1;
    acc = 16'h0000;
    // corners first: all rise, all fall, exact trip point, one below
    for (int k = 0; k < 24; k++) begin
      seed = lfsr(seed);
      oldT = temp;
      @(negedge sysClk);
      temp = (k < 4) ? CORNER[8*k +: 8] : seed[7:0];
      msgs = 0;
      repeat (4) begin
        @(negedge sysClk);
        msgs += int'(hostIntMsg_q === 1'b1);
      end
      // flags left set over two steps, so stickiness is seen too
      acc = acc | evFlags(oldT, temp);
      // only a rising trip sends a message, falls are left to the flags
      compareCount(int'(|(trips(temp) & ~trips(oldT))), msgs);
      wr(OFF_FLAGS_LO, 8'h00);
      rdChk(OFF_FLAGS_LO, acc[7:0]);
      rdChk(OFF_FLAGS_HI, acc[15:8]);
      rdChk(OFF_RELTEMP, temp);
      rdChk(OFF_CALTEMP, temp ^ 8'h3C);
      if (k % 2 == 1) begin
        wr(OFF_FLAGS_LO, 8'hFF);
        wr(OFF_FLAGS_HI, 8'hFF);
        acc = 16'h0000;
        rdChk(OFF_FLAGS_HI, 8'h00);
        rdChk(OFF_STAT_LO, {2'b00, trips(temp)});
      end
    end
    results;
  end
endmodule : tb_top
`default_nettype wire
